// >>> rtl/tpi_port.sv
// touch host port: two-wire target, word map access, ready window, resets
// assumes open-drain wires resolved outside and a core on the same mclk
// Notes on behaviour
// - answer as target 0x56; write byte 0xAC, read byte 0xAD.
// - bus clock up to 1 MHz is handled.
// - 16-bit word pointer, each address holds two bytes.
// - words go low byte first, then high byte.
// - after both bytes of a word the pointer advances by one.
// - a lone extended high byte reads from that block's start onward.
// - full extended address is high byte then low byte before the read.
// - ready line pulled low while a window is open, released otherwise.
// - clock may be stretched while data is prepared.
// - unserviced window closes after the millisecond timeout; data lost.
// - any reset sets the reset flag; only the acknowledge bit clears it.
// - software reset command bit resets the device.
// - clear pin held low resets the device.
// - two-byte settings version is kept and readable.
// - stay in setup loop until settings version is written.
// - slow-oscillator watchdog not restarted forces a cold boot.
// - a stop ending a transfer addressed to us closes the window.
// - after setup, a transfer outside a window is stretched until one opens, unless comms mode is on.
// - comms request 0xFF plus two bytes asks for the next window.
`timescale 1ns/1ps
`default_nettype none
`include "tpi_params.svh"
module tpi_port #(
  parameter int unsigned MS_CYCLES = `TPI_MS_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // two-wire bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // ready line, open drain
  output logic rdy_o,
  output logic rdy_oe,
  // reset pin and slow oscillator
  input wire logic clear_pin_n,
  input wire logic lfosc_i,
  // processing core
  input wire logic win_req,
  output logic win_done,
  output logic win_lost,
  output logic comms_req_pend,
  output logic setup_done,
  input wire logic wdt_kick,
  output logic core_rst_n,
  // memory map of the core
  output logic [15:0] app_addr,
  output logic [15:0] app_wdata,
  output logic app_wr,
  output logic app_rd,
  input wire logic [15:0] app_rdata
);
  import tpi_pkg::*;

  logic scl_s, sda_s, clr_s, lf_s, wdt_exp, rst_hold, serve_ok, stop_ev;
  logic scl_rise, scl_fall, start_c, stop_c, creq_set;
  logic [15:0] loc_rd;
  tpi_bus_st_t st_r, st_nxt;
  logic [3:0] bitc_r, bitc_nxt;
  logic [7:0] sh_r, sh_nxt, txb_r, txb_nxt, wlo_r, wlo_nxt;
  logic [15:0] txw_r, txw_nxt, ptr_r, ptr_nxt;
  logic [15:0] aa_r, aa_nxt, awd_r, awd_nxt;
  logic [1:0] nbyte_r, nbyte_nxt;
  logic rnw_r, rnw_nxt, ext_r, ext_nxt, half_r, half_nxt, nack_r, nack_nxt;
  logic sdad_r, sdad_nxt, sclh_r, sclh_nxt, fbusy_r, fbusy_nxt;
  logic fdone_r, fdone_nxt, adr_r, adr_nxt, scl_p_r, scl_p_nxt;
  logic sda_p_r, sda_p_nxt, aw_r, aw_nxt, lw_r, lw_nxt;
  logic fq_r, fq_nxt, rdv_r, rdv_nxt;
  logic show_r, show_nxt, cen_r, cen_nxt, setup_r, setup_nxt;
  logic soft_r, soft_nxt, crst_r, crst_nxt, win_r, win_nxt;
  logic creq_r, creq_nxt, done_r, done_nxt, lost_r, lost_nxt;
  logic [15:0] ver_r, ver_nxt, tmo_r, tmo_nxt, pre_r, pre_nxt, ms_r, ms_nxt;

  // words held here rather than in the core's map
  function automatic logic is_local(input logic [15:0] a);
    return a[15:8] == 8'h00 && (a[7:0] == `TPI_REG_SYS ||
      a[7:0] == `TPI_REG_VER || a[7:0] == `TPI_REG_TMO);
  endfunction

  tpi_sync #(.W(4)) u_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .d({lfosc_i, clear_pin_n, sda_i, scl_i}),
    .q({lf_s, clr_s, sda_s, scl_s})
  );

  tpi_wdt u_wdt (
    .clk(mclk),
    .rst_n(rst_n),
    .slow_lvl(lf_s),
    .kick(wdt_kick),
    .clr(rst_hold),
    .expire(wdt_exp)
  );

  assign scl_rise = scl_s && !scl_p_r;
  assign scl_fall = !scl_s && scl_p_r;
  assign start_c = scl_s && scl_p_r && sda_p_r && !sda_s;
  assign stop_c = scl_s && scl_p_r && !sda_p_r && sda_s;
  assign stop_ev = stop_c && adr_r;
  // soft reset waits for the stop so the command itself is acknowledged
  assign rst_hold = !clr_s || wdt_exp || (soft_r && stop_ev);
  // comms request mode must never stretch, so it serves at once
  assign serve_ok = win_r || !setup_r || cen_r;

  always_comb begin
    loc_rd = 16'h0000;
    case (aa_r[7:0])
      `TPI_REG_SYS: begin
        loc_rd[`TPI_SYS_SHOW_RESET] = show_r;
        loc_rd[`TPI_SYS_COMMS_EN] = cen_r;
        loc_rd[`TPI_SYS_SETUP_DONE] = setup_r;
      end
      `TPI_REG_VER: loc_rd = ver_r;
      `TPI_REG_TMO: loc_rd = tmo_r;
      default: loc_rd = 16'h0000;
    endcase
  end

  // bus engine
  always_comb begin
    st_nxt = st_r;
    bitc_nxt = bitc_r;
    sh_nxt = sh_r;
    txb_nxt = txb_r;
    txw_nxt = txw_r;
    wlo_nxt = wlo_r;
    ptr_nxt = ptr_r;
    aa_nxt = aa_r;
    awd_nxt = awd_r;
    nbyte_nxt = nbyte_r;
    rnw_nxt = rnw_r;
    ext_nxt = ext_r;
    half_nxt = half_r;
    nack_nxt = nack_r;
    sdad_nxt = sdad_r;
    sclh_nxt = sclh_r;
    fbusy_nxt = fbusy_r;
    fdone_nxt = fdone_r;
    adr_nxt = adr_r;
    scl_p_nxt = scl_s;
    sda_p_nxt = sda_s;
    aw_nxt = 1'b0;
    lw_nxt = 1'b0;
    fq_nxt = 1'b0;
    rdv_nxt = fq_r;
    creq_set = 1'b0;
    if (rdv_r) begin
      txw_nxt = is_local(aa_r) ? loc_rd : app_rdata;
      fdone_nxt = 1'b1;
      fbusy_nxt = 1'b0;
    end
    if (start_c) begin
      st_nxt = ST_ADDR;
      bitc_nxt = 4'h0;
      sdad_nxt = 1'b0;
      sclh_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt = ST_IDLE;
      adr_nxt = 1'b0;
      sdad_nxt = 1'b0;
      sclh_nxt = 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s};
            bitc_nxt = bitc_r + 4'h1;
          end else if (scl_fall && bitc_r == 4'h8) begin
            if (sh_r[7:1] == `TPI_TGT_ADDR) begin
              st_nxt = ST_AACK;
              sdad_nxt = 1'b1;
              rnw_nxt = sh_r[0];
              adr_nxt = 1'b1;
              nbyte_nxt = 2'h0;
              half_nxt = 1'b0;
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            sdad_nxt = 1'b0;
            sclh_nxt = 1'b1;
            fdone_nxt = 1'b0;
            st_nxt = ST_HOLD;
          end
        end
        ST_HOLD: begin
          // scl stays low here until serve_ok is true and, for a read, data is ready
          if (serve_ok) begin
            if (!rnw_r) begin
              st_nxt = ST_WR;
              bitc_nxt = 4'h0;
              sclh_nxt = 1'b0;
            end else if (fdone_r) begin
              txb_nxt = txw_r[7:0];
              sdad_nxt = !txw_r[7];
              half_nxt = 1'b0;
              bitc_nxt = 4'h0;
              fdone_nxt = 1'b0;
              sclh_nxt = 1'b0;
              st_nxt = ST_RD;
            end else if (!fbusy_r) begin
              aa_nxt = ptr_r;
              fq_nxt = 1'b1;
              fbusy_nxt = 1'b1;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s};
            bitc_nxt = bitc_r + 4'h1;
          end else if (scl_fall && bitc_r == 4'h8) begin
            st_nxt = ST_WACK;
            sdad_nxt = 1'b1;
            if (nbyte_r == 2'h0) begin
              half_nxt = 1'b0;
              if (cen_r && sh_r == `TPI_COMMS_REQ) begin
                creq_set = 1'b1;
                nbyte_nxt = 2'h3;
              end else if (sh_r >= `TPI_EXT_MIN) begin
                ptr_nxt = {sh_r, 8'h00};
                ext_nxt = 1'b1;
                nbyte_nxt = 2'h1;
              end else begin
                ptr_nxt = {8'h00, sh_r};
                ext_nxt = 1'b0;
                nbyte_nxt = 2'h2;
              end
            end else if (nbyte_r == 2'h1) begin
              ptr_nxt = {ptr_r[15:8], sh_r};
              nbyte_nxt = 2'h2;
            end else if (nbyte_r == 2'h2) begin
              if (!half_r) begin
                wlo_nxt = sh_r;
                half_nxt = 1'b1;
              end else begin
                aa_nxt = ptr_r;
                awd_nxt = {sh_r, wlo_r};
                lw_nxt = is_local(ptr_r);
                aw_nxt = !is_local(ptr_r);
                ptr_nxt = ptr_r + 16'h0001;
                half_nxt = 1'b0;
              end
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sdad_nxt = 1'b0;
            bitc_nxt = 4'h0;
            st_nxt = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            bitc_nxt = bitc_r + 4'h1;
            if (bitc_r == 4'h7) begin
              sdad_nxt = 1'b0;
              st_nxt = ST_RACK;
            end else begin
              txb_nxt = {txb_r[6:0], 1'b0};
              sdad_nxt = !txb_r[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall) begin
            if (nack_r) begin
              st_nxt = ST_IDLE;
            end else if (!half_r) begin
              txb_nxt = txw_r[15:8];
              sdad_nxt = !txw_r[15];
              half_nxt = 1'b1;
              bitc_nxt = 4'h0;
              st_nxt = ST_RD;
            end else begin
              ptr_nxt = ptr_r + 16'h0001;
              sclh_nxt = 1'b1;
              fdone_nxt = 1'b0;
              st_nxt = ST_HOLD;
            end
          end
        end
      endcase
    end
    if (rst_hold) begin
      st_nxt = ST_IDLE;
      sdad_nxt = 1'b0;
      sclh_nxt = 1'b0;
      adr_nxt = 1'b0;
      ptr_nxt = 16'h0000;
      fbusy_nxt = 1'b0;
      fdone_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      bitc_r <= 4'h0;
      sh_r <= 8'h00;
      txb_r <= 8'h00;
      txw_r <= 16'h0000;
      wlo_r <= 8'h00;
      ptr_r <= 16'h0000;
      aa_r <= 16'h0000;
      awd_r <= 16'h0000;
      nbyte_r <= 2'h0;
      rnw_r <= 1'b0;
      ext_r <= 1'b0;
      half_r <= 1'b0;
      nack_r <= 1'b0;
      sdad_r <= 1'b0;
      sclh_r <= 1'b0;
      fbusy_r <= 1'b0;
      fdone_r <= 1'b0;
      adr_r <= 1'b0;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      aw_r <= 1'b0;
      lw_r <= 1'b0;
      fq_r <= 1'b0;
      rdv_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bitc_r <= bitc_nxt;
      sh_r <= sh_nxt;
      txb_r <= txb_nxt;
      txw_r <= txw_nxt;
      wlo_r <= wlo_nxt;
      ptr_r <= ptr_nxt;
      aa_r <= aa_nxt;
      awd_r <= awd_nxt;
      nbyte_r <= nbyte_nxt;
      rnw_r <= rnw_nxt;
      ext_r <= ext_nxt;
      half_r <= half_nxt;
      nack_r <= nack_nxt;
      sdad_r <= sdad_nxt;
      sclh_r <= sclh_nxt;
      fbusy_r <= fbusy_nxt;
      fdone_r <= fdone_nxt;
      adr_r <= adr_nxt;
      scl_p_r <= scl_p_nxt;
      sda_p_r <= sda_p_nxt;
      aw_r <= aw_nxt;
      lw_r <= lw_nxt;
      fq_r <= fq_nxt;
      rdv_r <= rdv_nxt;
    end
  end

  // local words, window and timeout
  always_comb begin
    show_nxt = show_r;
    cen_nxt = cen_r;
    setup_nxt = setup_r;
    soft_nxt = soft_r;
    ver_nxt = ver_r;
    tmo_nxt = tmo_r;
    win_nxt = win_r;
    creq_nxt = creq_r;
    pre_nxt = pre_r;
    ms_nxt = ms_r;
    done_nxt = 1'b0;
    lost_nxt = 1'b0;
    crst_nxt = !rst_hold;
    if (lw_r) begin
      case (aa_r[7:0])
        `TPI_REG_SYS: begin
          if (awd_r[`TPI_SYS_ACK_RESET]) show_nxt = 1'b0;
          if (awd_r[`TPI_SYS_SOFT_RESET]) soft_nxt = 1'b1;
          cen_nxt = awd_r[`TPI_SYS_COMMS_EN];
        end
        `TPI_REG_VER: begin
          ver_nxt = awd_r;
          setup_nxt = 1'b1;
        end
        `TPI_REG_TMO: tmo_nxt = awd_r;
        default: ;
      endcase
    end
    if (win_req && setup_r && !win_r) begin
      win_nxt = 1'b1;
      creq_nxt = 1'b0;
      pre_nxt = 16'h0000;
      ms_nxt = 16'h0000;
    end else if (win_r) begin
      if (stop_ev) begin
        win_nxt = 1'b0;
        done_nxt = 1'b1;
      end else if (tmo_r != 16'h0000 && st_r == ST_IDLE) begin
        // time only runs while nobody is talking to us
        if (ms_r >= tmo_r) begin
          win_nxt = 1'b0;
          lost_nxt = 1'b1;
        end else if (pre_r == 16'(MS_CYCLES - 1)) begin
          pre_nxt = 16'h0000;
          ms_nxt = ms_r + 16'h0001;
        end else begin
          pre_nxt = pre_r + 16'h0001;
        end
      end
    end
    if (creq_set) creq_nxt = 1'b1;
    if (rst_hold) begin
      show_nxt = 1'b1;
      soft_nxt = 1'b0;
      cen_nxt = 1'b0;
      setup_nxt = `TPI_PRESET_DEFAULTS;
      ver_nxt = `TPI_VER_RESET;
      tmo_nxt = `TPI_TMO_RESET;
      win_nxt = 1'b0;
      creq_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      show_r <= 1'b1;
      cen_r <= 1'b0;
      setup_r <= `TPI_PRESET_DEFAULTS;
      soft_r <= 1'b0;
      ver_r <= `TPI_VER_RESET;
      tmo_r <= `TPI_TMO_RESET;
      win_r <= 1'b0;
      creq_r <= 1'b0;
      pre_r <= 16'h0000;
      ms_r <= 16'h0000;
      done_r <= 1'b0;
      lost_r <= 1'b0;
      crst_r <= 1'b0;
    end else begin
      show_r <= show_nxt;
      cen_r <= cen_nxt;
      setup_r <= setup_nxt;
      soft_r <= soft_nxt;
      ver_r <= ver_nxt;
      tmo_r <= tmo_nxt;
      win_r <= win_nxt;
      creq_r <= creq_nxt;
      pre_r <= pre_nxt;
      ms_r <= ms_nxt;
      done_r <= done_nxt;
      lost_r <= lost_nxt;
      crst_r <= crst_nxt;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign rdy_o = 1'b0;
  assign scl_oe = sclh_r;
  assign sda_oe = sdad_r;
  assign rdy_oe = win_r;
  assign win_done = done_r;
  assign win_lost = lost_r;
  assign comms_req_pend = creq_r;
  assign setup_done = setup_r;
  assign core_rst_n = crst_r;
  assign app_addr = aa_r;
  assign app_wdata = awd_r;
  assign app_wr = aw_r;
  assign app_rd = fq_r && !is_local(aa_r);
endmodule
`default_nettype wire

// >>> rtl/tpi_params.svh
// touch host port: offsets, field positions, reset values and timing counts
// assumes inclusion by the port and the watchdog modules, after the default nettype
`ifndef TPI_PARAMS_SVH
`define TPI_PARAMS_SVH
// bus target address and special first bytes
`define TPI_TGT_ADDR 7'h56
`define TPI_EXT_MIN 8'hE0
`define TPI_COMMS_REQ 8'hFF
// local word registers inside the 8-bit map
`define TPI_REG_SYS 8'hC0
`define TPI_REG_VER 8'hC1
`define TPI_REG_TMO 8'hC2
// system word fields
`define TPI_SYS_ACK_RESET 0
`define TPI_SYS_SOFT_RESET 1
`define TPI_SYS_COMMS_EN 2
`define TPI_SYS_SHOW_RESET 3
`define TPI_SYS_SETUP_DONE 4
// reset values
`define TPI_VER_RESET 16'h0000
`define TPI_TMO_RESET 16'h000A
`define TPI_PRESET_DEFAULTS 1'b0
// timing
`define TPI_CLK_NS 40
`define TPI_MS_NS 1000000
`define TPI_MS_CYCLES (`TPI_MS_NS / `TPI_CLK_NS)
`define TPI_WDT_TICKS 11'h3E8
`endif

// >>> rtl/tpi_pkg.sv
// touch host port: shared types
// assumes nothing beyond a SystemVerilog compiler
package tpi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_HOLD, ST_WR, ST_WACK, ST_RD, ST_RACK
  } tpi_bus_st_t;
endpackage

// >>> rtl/tpi_sync.sv
// touch host port: three-stage pin synchroniser with agreement filter
// assumes asynchronous pins that idle high
`timescale 1ns/1ps
`default_nettype none
module tpi_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, filtered levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

  // a bit moves only once the second and third stage agree
  always_comb begin
    q_nxt = (s3_r & ~(s2_r ^ s3_r)) | (q_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      q_r <= '1;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

// >>> rtl/tpi_wdt.sv
// touch host port: watchdog counting edges of the slow always-on oscillator
// assumes slow_lvl is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
`include "tpi_params.svh"
module tpi_wdt (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // slow oscillator level, loop kick and count clear
  input wire logic slow_lvl,
  input wire logic kick,
  input wire logic clr,
  // expiry pulse
  output logic expire
);
  logic slow_p_r, slow_p_nxt, exp_r, exp_nxt;
  logic [10:0] slow_tick_timer_r, slow_tick_timer_nxt;

  always_comb begin
    slow_p_nxt = slow_lvl;
    slow_tick_timer_nxt = slow_tick_timer_r;
    exp_nxt = 1'b0;
    if (kick || clr) begin
      slow_tick_timer_nxt = 11'h000;
    end else if (slow_lvl && !slow_p_r) begin
      // expiry forces a cold boot, so the count starts over afterwards
      if (slow_tick_timer_r == `TPI_WDT_TICKS - 11'h001) begin
        slow_tick_timer_nxt = 11'h000;
        exp_nxt = 1'b1;
      end else begin
        slow_tick_timer_nxt = slow_tick_timer_r + 11'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_p_r <= 1'b1;
      slow_tick_timer_r <= 11'h000;
      exp_r <= 1'b0;
    end else begin
      slow_p_r <= slow_p_nxt;
      slow_tick_timer_r <= slow_tick_timer_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expire = exp_r;
endmodule
`default_nettype wire

// >>> tb/tpi_port_monitor.sv
// touch host port checker: port-level timing relations of the target
// assumes one clock domain, mclk, with rst_n as its asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module tpi_port_chk #(
  parameter int unsigned MS_CYCLES = 25000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic rdy_o,
  input wire logic rdy_oe,
  input wire logic clear_pin_n,
  // core side
  input wire logic win_req,
  input wire logic win_done,
  input wire logic win_lost,
  input wire logic setup_done,
  input wire logic core_rst_n,
  input wire logic [15:0] app_addr,
  input wire logic app_wr,
  input wire logic app_rd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_pins_low: assert property (!scl_o && !sda_o && !rdy_o)
    else $error("open-drain output level not low");
  // bus bytes are far apart, so two core strobes close together are a fault
  chk_wr_spacing: assert property (app_wr |=> !app_wr [*8])
    else $error("core write repeated too soon");
  chk_rd_spacing: assert property (app_rd |=> !app_rd [*8])
    else $error("core read repeated too soon");
  chk_local_kept: assert property (app_wr |->
    !(app_addr inside {[16'h00C0:16'h00C2]}))
    else $error("local word write leaked to core");
  chk_done_closes: assert property (win_done |-> !rdy_oe)
    else $error("window still open after stop");
  chk_lost_closes: assert property (
    win_lost |-> !rdy_oe && $past(rdy_oe))
    else $error("timeout without an open window");
  chk_win_open: assert property (
    win_req && setup_done && !rdy_oe && core_rst_n |=> rdy_oe)
    else $error("window did not open on request");
  chk_setup_gate: assert property (!setup_done |-> !rdy_oe)
    else $error("window open during setup loop");
  chk_pin_reset: assert property (
    !clear_pin_n [*8] |-> !core_rst_n)
    else $error("clear pin did not reset core");
endmodule
bind tpi_port tpi_port_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .scl_o(scl_o), .sda_o(sda_o),
  .rdy_o(rdy_o), .rdy_oe(rdy_oe), .clear_pin_n(clear_pin_n),
  .win_req(win_req), .win_done(win_done), .win_lost(win_lost),
  .setup_done(setup_done), .core_rst_n(core_rst_n),
  .app_addr(app_addr), .app_wr(app_wr), .app_rd(app_rd)
);
`default_nettype wire

// >>> tb/tpi_host.sv
// touch host port bench: bus controller model of the host
// assumes the bench resolves both lines with pull-ups from all pull-downs
`timescale 1ns/1ps
`default_nettype none
module tpi_host #(
  parameter int Q = 8
) (
  // clock
  input wire logic mclk,
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // our pull-downs
  output logic scl_pull,
  output logic sda_pull
);
  // three waits of q cycles plus the rise keep a bit at 1 us or more on a 40 ns clock
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic wt(int n);
    repeat (n) @(posedge mclk);
  endtask
  // release scl and wait while the target stretches it
  task automatic rise();
    int k;
    k = 0;
    scl_pull <= 1'b0;
    wt(1);
    while (scl !== 1'b1 && k < 4000) begin
      wt(1);
      k++;
    end
    wt(Q);
  endtask
  task automatic bit_out(logic b);
    sda_pull <= !b;
    wt(Q);
    rise();
    scl_pull <= 1'b1;
    wt(Q);
  endtask
  task automatic bit_in(output logic b);
    sda_pull <= 1'b0;
    wt(Q);
    rise();
    b = sda;
    scl_pull <= 1'b1;
    wt(Q);
  endtask
  // serves as repeated start too, since scl is low between bytes
  task automatic start();
    sda_pull <= 1'b0;
    wt(Q);
    rise();
    sda_pull <= 1'b1;
    wt(Q);
    scl_pull <= 1'b1;
    wt(Q);
  endtask
  task automatic stop();
    sda_pull <= 1'b1;
    wt(Q);
    rise();
    sda_pull <= 1'b0;
    wt(2 * Q);
  endtask
  task automatic wbyte(logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    bit_in(a);
    ack = !a;
  endtask
  task automatic rbyte(logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_in(v[i]);
    bit_out(last);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// touch host port bench: host model on the bus, a stand-in core behind
// assumes tpi_host and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, rst_n, clear_pin_n, lfosc_i, win_req, wdt_kick, k;
  logic scl_o, scl_oe, sda_o, sda_oe, rdy_o, rdy_oe, h_scl, h_sda;
  logic win_done, win_lost, comms_req_pend, setup_done, core_rst_n;
  logic app_wr, app_rd, lost_seen, rst_seen, done_seen;
  logic [15:0] app_addr, app_wdata, app_rdata;
  logic [15:0] wq[$], raq[$], w[$];
  int bad_count, samples_checked, cyc, n;
  localparam logic [15:0] K = 16'h5A3C;
  wire scl = !(h_scl | scl_oe);
  wire sda = !(h_sda | sda_oe);
  tpi_port #(.MS_CYCLES(10)) u_tpi_port (.mclk(mclk), .rst_n(rst_n),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .rdy_o(rdy_o), .rdy_oe(rdy_oe),
    .clear_pin_n(clear_pin_n), .lfosc_i(lfosc_i), .win_req(win_req),
    .win_done(win_done), .win_lost(win_lost),
    .comms_req_pend(comms_req_pend), .setup_done(setup_done),
    .wdt_kick(wdt_kick), .core_rst_n(core_rst_n), .app_addr(app_addr),
    .app_wdata(app_wdata), .app_wr(app_wr), .app_rd(app_rd),
    .app_rdata(app_rdata));
  tpi_host u_tpi_host (.mclk(mclk), .scl(scl), .sda(sda),
    .scl_pull(h_scl), .sda_pull(h_sda));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // stand-in core, slow oscillator at eight cycles a period, hang limit
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) lfosc_i <= !lfosc_i;
    if (app_rd) app_rdata <= app_addr ^ K;
    if (app_rd) raq.push_back(app_addr);
    if (app_wr) wq.push_back(app_addr);
    if (app_wr) wq.push_back(app_wdata);
    if (win_lost) lost_seen <= 1'b1;
    if (win_done) done_seen <= 1'b1;
    if (!core_rst_n) rst_seen <= 1'b1;
    if (cyc == 60000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cw(logic [15:0] g, logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cb(logic g, logic e);
    cw({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic cq(logic [15:0] g[$], logic [15:0] e[$]);
    cw(16'(g.size()), 16'(e.size()));
    foreach (e[i]) cw(g[i], e[i]);
  endtask
  task automatic wt(int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic win();
    win_req <= 1'b1;
    wt(1);
    win_req <= 1'b0;
    wt(3);
  endtask
  task automatic put(logic [7:0] q[$], logic fin);
    logic a;
    u_tpi_host.start();
    u_tpi_host.wbyte(8'hAC, a);
    cb(a, 1'b1);
    foreach (q[i]) u_tpi_host.wbyte(q[i], a);
    if (fin) u_tpi_host.stop();
  endtask
  // pointer bytes, repeated start, then c words read low byte first
  task automatic get(logic [7:0] q[$], int c);
    logic a;
    logic [7:0] lo, hi;
    w = {};
    put(q, 1'b0);
    u_tpi_host.start();
    u_tpi_host.wbyte(8'hAD, a);
    for (int i = 0; i < c; i++) begin
      u_tpi_host.rbyte(1'b0, lo);
      u_tpi_host.rbyte(i == c - 1, hi);
      w.push_back({hi, lo});
    end
    u_tpi_host.stop();
  endtask
  initial begin
    rst_n = 1'b0;
    clear_pin_n = 1'b1;
    lfosc_i = 1'b0;
    win_req = 1'b0;
    wdt_kick = 1'b1;
    app_rdata = 16'h0000;
    {bad_count, samples_checked, cyc} = '0;
    {lost_seen, rst_seen, done_seen} = 3'b000;
    wt(6);
    rst_n <= 1'b1;
    wt(8);
    get('{8'hC0}, 3);
    cq(w, '{16'h0008, 16'h0000, 16'h000A});
    put('{8'hC0, 8'h01, 8'h00}, 1'b1);
    get('{8'hC0}, 1);
    cw(w[0] & 16'h0008, 16'h0000);
    // a trailing lone low byte must be dropped
    put('{8'h40, 8'h34, 8'h12, 8'h78, 8'h56, 8'h9A}, 1'b1);
    cq(wq, '{16'h0040, 16'h1234, 16'h0041, 16'h5678});
    get('{8'h10}, 2);
    cq(w, '{16'h0010 ^ K, 16'h0011 ^ K});
    get('{8'hE0}, 2);
    cq(w, '{16'hE000 ^ K, 16'hE001 ^ K});
    get('{8'hE0, 8'h03}, 1);
    cw(w[0], 16'hE003 ^ K);
    cq(raq, '{16'h0010, 16'h0011, 16'hE000, 16'hE001, 16'hE003});
    cw(16'(wq.size()), 16'h0004);
    u_tpi_host.start();
    u_tpi_host.wbyte(8'hAE, k);
    u_tpi_host.stop();
    cb(k, 1'b0);
    // five ms: a window must outlast the ~33 cycles a host start takes
    put('{8'hC2, 8'h05, 8'h00}, 1'b1);
    put('{8'hC1, 8'h02, 8'h01}, 1'b1);
    cb(setup_done, 1'b1);
    win();
    cb(rdy_oe, 1'b1);
    get('{8'hC1}, 1);
    wt(2);
    cb(rdy_oe, 1'b0);
    cb(done_seen, 1'b1);
    cw(w[0], 16'h0102);
    win();
    wt(60);
    cb(rdy_oe, 1'b0);
    cb(lost_seen, 1'b1);
    fork
      get('{8'h11}, 1);
      begin
        wt(400);
        cb(scl_oe & !rdy_oe, 1'b1);
        win();
      end
    join
    cw(w[0], 16'h0011 ^ K);
    win();
    put('{8'hC0, 8'h04, 8'h00}, 1'b1);
    put('{8'hFF, 8'h11, 8'h22}, 1'b1);
    cb(comms_req_pend, 1'b1);
    win();
    cb(rdy_oe & !comms_req_pend, 1'b1);
    rst_seen <= 1'b0;
    put('{8'hC0, 8'h02, 8'h00}, 1'b1);
    wt(4);
    cb(rst_seen, 1'b1);
    get('{8'hC0}, 1);
    cw(w[0] & 16'h001C, 16'h0008);
    put('{8'hC0, 8'h01, 8'h00}, 1'b1);
    clear_pin_n <= 1'b0;
    wt(10);
    cb(core_rst_n, 1'b0);
    clear_pin_n <= 1'b1;
    wt(8);
    get('{8'hC0}, 1);
    cw(w[0] & 16'h0008, 16'h0008);
    wdt_kick <= 1'b0;
    n = 0;
    while (core_rst_n === 1'b1 && n < 9000) begin
      wt(1);
      n++;
    end
    cb(core_rst_n, 1'b0);
    cb(n > 7000, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
